// File: hdl/amp_output_protection_ctrl.sv
// fault protection controller of a four half-bridge pwm stage
// assumes comparator flags on pins, apb master on the system clock
// Contract
// RL1 - setting picks protection mode and trip threshold
// RL2 - out of range setting gives lowest threshold
// RL3 - overcurrent flips half-bridge until next frame
// RL4 - count up per event, down per clean frame
// RL5 - full counter shuts channel until reset cycle
// RL6 - counter maximum is a design parameter
// RL7 - latched mode shuts on first overcurrent
// RL8 - inject pulse every 4th frame when saturated
// RL9 - clipping pulses warning output, self clearing
// RL10 - dc imbalance counts up, then shuts channel
// RL11 - no dc protection in parallel or single-ended
// RL12 - pin check only when logic supply appears
// RL13 - check ground shorts first, then supply shorts
// RL14 - short found holds all outputs off
// RL15 - fault low and reset ignored during check
// RL16 - reset does not restart pin check
// RL17 - check skipped in single-ended mode
// RL18 - warning above 125C, latched shutdown above 155C
// RL19 - heat shutdown clears only by reset
// RL20 - power-on reset clears overload logic
// RL21 - low supply turns off outputs, fault low
// RL22 - low supply recovers without reset
// RL23 - every shutdown drives fault low
// RL24 - reset low forces fault high
// RL25 - controller waits 4 ms before releasing reset (model default: 200 cycles after fault falls, 4 us at 50 MHz)
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "amp_prot_cfg.svh"
module amp_output_protection_ctrl #(
    parameter logic [7:0] OL_MAX = `OL_MAX_DEF
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic [3:0]  i_overcurrent_setting_input,
    input  wire logic        i_device_reset_n,
    input  wire logic [3:0]  i_overcurrent,
    input  wire logic        i_pwm_frame,
    input  wire logic        i_clipping,
    input  wire logic        i_heat_warning,
    input  wire logic        i_heat_shutdown,
    input  wire logic        i_supplies_ok,
    input  wire logic        i_logic_supply_up,
    input  wire logic        i_short_to_ground,
    input  wire logic        i_short_to_stage_supply,
    input  wire logic [1:0]  i_dc_imbalance,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [3:0]       o_hiz,
    output logic [3:0]       o_flip,
    output logic             o_inject,
    output logic             o_fault_n,
    output logic             o_clip_heat_warning_n,
    output logic             o_cycle_limit_mode,
    output logic [1:0]       o_oc_threshold
);
    amp_prot_pkg::prot_state_t st;
    amp_prot_pkg::prot_state_t next_st;
    amp_prot_pkg::pin_sync_t   pins;
    amp_prot_pkg::pin_sync_t   s;

    logic       frame;
    logic       running;
    logic       reset_low;
    logic       base_off;
    logic [3:0] oc_lim;
    logic [1:0] oc_ch;
    logic [1:0] imb_en;
    logic [1:0] at_max;
    logic [7:0] count0;
    logic [7:0] count1;
    logic       ol_clear;
    logic       setup;
    logic       wr;

    assign pins = '{setting:   i_overcurrent_setting_input,
                    reset_pin: i_device_reset_n,
                    imbalance: i_dc_imbalance,
                    short_sup: i_short_to_stage_supply,
                    short_gnd: i_short_to_ground,
                    logic_up:  i_logic_supply_up,
                    supply_ok: i_supplies_ok,
                    heat_shut: i_heat_shutdown,
                    heat_warn: i_heat_warning,
                    clip:      i_clipping,
                    frame:     i_pwm_frame,
                    oc:        i_overcurrent};
    assign s = st.sync2;

    // frame start, reset pin honoured only after the check
    assign frame     = s.frame && !st.frame_prev;
    assign running   = (st.chk == amp_prot_pkg::st_run);
    assign reset_low = running && !s.reset_pin; // see RL15
    assign base_off  = !running || st.heat_shutdown
                       || !s.supply_ok || reset_low;
    assign oc_lim    = (st.latched_mode || base_off) ? 4'h0 : s.oc;
    assign oc_ch     = {|oc_lim[3:2], |oc_lim[1:0]};
    assign imb_en    = (st.out_mode == `MODE_BRIDGED && running)
                       ? s.imbalance : 2'h0; // see RL11
    assign ol_clear  = reset_low;
    assign setup     = i_psel && !i_penable;
    assign wr        = i_psel && i_penable && i_pwrite;

    overload_counter #(
        .OL_MAX (OL_MAX)
    ) u_ol0 (
        .i_clk_sys   (i_clk_sys),
        .i_resetn    (i_resetn),
        .i_clear     (ol_clear),
        .i_frame     (frame),
        .i_oc_seen   (st.oc_seen[0] || oc_ch[0]),
        .i_imbalance (imb_en[0]),
        .o_count     (count0),
        .o_at_max    (at_max[0])
    );

    overload_counter #(
        .OL_MAX (OL_MAX)
    ) u_ol1 (
        .i_clk_sys   (i_clk_sys),
        .i_resetn    (i_resetn),
        .i_clear     (ol_clear),
        .i_frame     (frame),
        .i_oc_seen   (st.oc_seen[1] || oc_ch[1]),
        .i_imbalance (imb_en[1]),
        .o_count     (count1),
        .o_at_max    (at_max[1])
    );

    always_comb begin
        next_st            = st;
        next_st.sync1      = pins;
        next_st.sync2      = st.sync1;
        next_st.frame_prev = s.frame;
        // setting decode
        next_st.latched_mode = (s.setting >= `SET_LATCH_LO)
                               && (s.setting <= `SET_LATCH_HI); // see RL1
        if (s.setting <= `SET_LATCH_HI) begin
            next_st.threshold = s.setting[1:0]; // see RL1
        end else begin
            next_st.threshold = `THR_LOWEST; // see RL2
        end
        // startup pin check
        case (st.chk)
            amp_prot_pkg::st_wait: begin
                next_st.step_cnt = '0;
                if (s.logic_up) begin // see RL12
                    if (st.out_mode == `MODE_SINGLE) begin
                        next_st.chk = amp_prot_pkg::st_run; // see RL17
                    end else begin
                        next_st.chk = amp_prot_pkg::st_gnd; // see RL13
                    end
                end
            end
            amp_prot_pkg::st_gnd, amp_prot_pkg::st_sup: begin
                next_st.step_cnt = st.step_cnt + 12'h001;
                if (!s.logic_up) begin
                    next_st.chk = amp_prot_pkg::st_wait;
                end else if ((st.chk == amp_prot_pkg::st_gnd)
                             ? s.short_gnd : s.short_sup) begin
                    next_st.step_cnt = '0; // see RL14
                end else if (st.step_cnt ==
                             `STEP_W'(`CHECK_STEP_CYC - 1)) begin
                    next_st.step_cnt = '0;
                    if (st.chk == amp_prot_pkg::st_gnd) begin
                        next_st.chk = amp_prot_pkg::st_sup; // see RL13
                    end else begin
                        next_st.chk = amp_prot_pkg::st_run;
                    end
                end
            end
            amp_prot_pkg::st_run: begin
                next_st.step_cnt = '0;
                if (!s.logic_up) begin // see RL16
                    next_st.chk = amp_prot_pkg::st_wait;
                end
            end
            default: begin
                next_st.chk = amp_prot_pkg::st_wait;
            end
        endcase
        // heat shutdown latch, set wins over reset
        if (s.heat_shut) begin
            next_st.heat_shutdown = 1'b1; // see RL18
        end else if (reset_low) begin
            next_st.heat_shutdown = 1'b0; // see RL19
        end
        // channel shutdown latches
        if (reset_low) begin
            next_st.chan_shut = 2'h0; // see RL5
        end else begin
            next_st.chan_shut = st.chan_shut | at_max; // see RL5 RL10
            if (st.latched_mode && !base_off) begin
                next_st.chan_shut = next_st.chan_shut
                    | {|s.oc[3:2], |s.oc[1:0]}; // see RL7
            end
        end
        // cycle limiting per half-bridge
        if (frame) begin
            next_st.flip     = oc_lim; // see RL3
            next_st.oc_seen  = 2'h0;
            next_st.limiting = |oc_lim;
        end else begin
            next_st.flip     = st.flip | oc_lim; // see RL3
            next_st.oc_seen  = st.oc_seen | oc_ch; // see RL4
            next_st.limiting = st.limiting | (|oc_lim);
        end
        // pulse injection while saturated
        next_st.inject = 1'b0;
        if (frame) begin
            if (s.clip || st.limiting) begin
                next_st.inj_cnt = st.inj_cnt + 2'h1;
                next_st.inject  = (st.inj_cnt == `INJECT_LAST); // see RL8
            end else begin
                next_st.inj_cnt = 2'h0;
            end
        end
        // fault and warning pins
        next_st.warn_n = !(s.clip || s.heat_warn); // see RL9 RL18
        if (reset_low) begin
            next_st.fault_n = 1'b1; // see RL24
        end else begin
            next_st.fault_n = !(!running || st.heat_shutdown
                                || (|st.chan_shut)
                                || !s.supply_ok); // see RL15 RL21 RL23
        end
        // half-bridge enables
        if (base_off || (st.out_mode == `MODE_PARALLEL
                         && (|st.chan_shut))) begin
            next_st.hiz = 4'hF; // see RL14 RL21 RL22
        end else begin
            next_st.hiz = {{2{st.chan_shut[1]}}, {2{st.chan_shut[0]}}};
        end
        // register bus
        if (setup) begin
            next_st.slverr = 1'b0;
            case (i_paddr)
                `REG_CFG:    next_st.rdata = {30'h0, st.out_mode};
                `REG_STATUS: next_st.rdata = {16'h0, st.chk,
                    st.heat_shutdown, st.chan_shut, st.latched_mode,
                    st.threshold, st.fault_n, st.warn_n, st.hiz};
                `REG_COUNT:  next_st.rdata = {16'h0, count1, count0};
                default: begin
                    next_st.rdata  = 32'h0;
                    next_st.slverr = 1'b1;
                end
            endcase
        end
        if (wr && i_paddr == `REG_CFG) begin
            next_st.out_mode = i_pwdata[1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st          <= '0; // see RL20
            st.chk      <= amp_prot_pkg::st_wait;
            st.out_mode <= `CFG_RESET;
            st.fault_n  <= 1'b1;
            st.warn_n   <= 1'b1;
            st.hiz      <= 4'hF;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata              = st.rdata;
    assign o_pready              = 1'b1;
    assign o_pslverr             = i_psel && i_penable && st.slverr;
    assign o_hiz                 = st.hiz;
    assign o_flip                = st.flip;
    assign o_inject              = st.inject;
    assign o_fault_n             = st.fault_n;
    assign o_clip_heat_warning_n = st.warn_n;
    assign o_cycle_limit_mode    = !st.latched_mode;
    assign o_oc_threshold        = st.threshold;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    sequence s_gnd_done;
        (st.chk == amp_prot_pkg::st_gnd) ##1
        (st.chk != amp_prot_pkg::st_gnd);
    endsequence

    chk_check_order: assert property ( // see RL13
        s_gnd_done |-> st.chk inside {amp_prot_pkg::st_sup,
                                      amp_prot_pkg::st_wait})
        else $error("pin check steps out of order");
    chk_check_fault: assert property ( // see RL15
        !running |=> !o_fault_n && o_hiz == 4'hF)
        else $error("fault not low during pin check");
    chk_reset_high: assert property ( // see RL24
        reset_low |=> o_fault_n)
        else $error("fault not forced high in reset");
    chk_low_supply: assert property ( // see RL21
        (running && !s.supply_ok && !reset_low)
        |=> o_hiz == 4'hF && !o_fault_n)
        else $error("low supply did not shut down");
    chk_heat_latch: assert property ( // see RL19
        (st.heat_shutdown && !reset_low) |=> st.heat_shutdown)
        else $error("heat shutdown lost without reset");
    chk_heat_warn: assert property ( // see RL18
        s.heat_warn |=> !o_clip_heat_warning_n)
        else $error("heat warning not shown");
    chk_first_trip: assert property ( // see RL7
        (st.latched_mode && !base_off && s.oc[0] && !reset_low)
        |=> st.chan_shut[0] ##1 o_hiz[1:0] == 2'h3)
        else $error("latched mode did not trip");
    chk_flip_clear: assert property ( // see RL3
        (frame && s.oc == 4'h0) |=> o_flip == 4'h0)
        else $error("flip not cleared at frame start");
    chk_setting_min: assert property ( // see RL2
        (s.setting > `SET_LATCH_HI) |=> o_oc_threshold == `THR_LOWEST)
        else $error("invalid setting not at lowest threshold");
    chk_run_stays: assert property ( // see RL16
        (running && s.logic_up) |=> running)
        else $error("pin check restarted without supply loss");
    chk_inject_cause: assert property ( // see RL8
        o_inject |-> $past(s.clip || st.limiting) && st.inj_cnt == 2'h0)
        else $error("inject pulse without saturation");
endmodule

// File: hdl/amp_prot_cfg.svh
// constants of the output protection controller
// assumes a 50 MHz system clock
`ifndef AMP_PROT_CFG_SVH
`define AMP_PROT_CFG_SVH
`define CLK_PERIOD_NS   20
`define CHECK_STEP_NS   40000
`define CHECK_STEP_CYC  (`CHECK_STEP_NS / `CLK_PERIOD_NS)
`define STEP_W          12
`define OL_MAX_DEF      8'h3F
`define OL_ZERO         8'h00
`define OL_ONE          8'h01
`define INJECT_LAST     2'h3
`define SET_LIMIT_HI    4'h3
`define SET_LATCH_LO    4'h4
`define SET_LATCH_HI    4'h7
`define THR_LOWEST      2'h3
`define REG_CFG         12'h000
`define REG_STATUS      12'h004
`define REG_COUNT       12'h008
`define CFG_RESET       2'h0
`define MODE_BRIDGED    2'h0
`define MODE_PARALLEL   2'h1
`define MODE_SINGLE     2'h2
`endif

// File: hdl/amp_prot_pkg.sv
// types of the output protection controller
// assumes amp_prot_cfg.svh for the numbers
package amp_prot_pkg;
    typedef enum logic [3:0] {
        st_wait = 4'h1,
        st_gnd  = 4'h2,
        st_sup  = 4'h4,
        st_run  = 4'h8
    } check_state_t;

    typedef struct packed {
        logic [3:0] setting;
        logic       reset_pin;
        logic [1:0] imbalance;
        logic       short_sup;
        logic       short_gnd;
        logic       logic_up;
        logic       supply_ok;
        logic       heat_shut;
        logic       heat_warn;
        logic       clip;
        logic       frame;
        logic [3:0] oc;
    } pin_sync_t;

    typedef struct packed {
        pin_sync_t    sync1;
        pin_sync_t    sync2;
        logic         frame_prev;
        check_state_t chk;
        logic [11:0]  step_cnt;
        logic [1:0]   out_mode;
        logic         latched_mode;
        logic [1:0]   threshold;
        logic         heat_shutdown;
        logic [1:0]   chan_shut;
        logic [3:0]   flip;
        logic [1:0]   oc_seen;
        logic         limiting;
        logic [1:0]   inj_cnt;
        logic         inject;
        logic         fault_n;
        logic         warn_n;
        logic [3:0]   hiz;
        logic [31:0]  rdata;
        logic         slverr;
    } prot_state_t;

    typedef struct packed {
        logic [7:0] count;
    } ol_state_t;
endpackage

// File: hdl/overload_counter.sv
// up/down overload counter of one output channel
// assumes i_frame is a one-cycle pulse per pwm frame
`timescale 1ns/100ps
`include "amp_prot_cfg.svh"
module overload_counter #(
    parameter logic [7:0] OL_MAX = `OL_MAX_DEF
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_clear,
    input  wire logic       i_frame,
    input  wire logic       i_oc_seen,
    input  wire logic       i_imbalance,
    output logic [7:0]      o_count,
    output logic            o_at_max
);
    amp_prot_pkg::ol_state_t st;
    amp_prot_pkg::ol_state_t next_st;

    always_comb begin
        next_st = st;
        if (i_clear) begin
            next_st.count = `OL_ZERO;
        end else if (i_frame) begin
            if (i_oc_seen || i_imbalance) begin
                if (st.count != OL_MAX) begin // see RL4 RL10
                    next_st.count = st.count + `OL_ONE;
                end
            end else if (st.count != `OL_ZERO) begin // see RL4
                next_st.count = st.count - `OL_ONE;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0; // see RL20
        end else begin
            st <= next_st;
        end
    end

    assign o_count  = st.count;
    assign o_at_max = (st.count == OL_MAX); // see RL5 RL6

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    chk_count_rises: assert property ( // see RL4
        (i_frame && i_oc_seen && !i_clear && st.count != OL_MAX)
        |=> st.count == $past(st.count) + `OL_ONE)
        else $error("overload count did not rise");
    chk_count_falls: assert property ( // see RL4
        (i_frame && !i_oc_seen && !i_imbalance && !i_clear
         && st.count != `OL_ZERO)
        |=> st.count == $past(st.count) - `OL_ONE)
        else $error("overload count did not fall");
endmodule

// File: verif/sys_ctrl_model.sv
// model of the system controller on the fault and reset pins
// assumes one clock domain shared with the protection block
`timescale 1ns/100ps
module sys_ctrl_model #(
    parameter int HOLD_CYC = 200
) (
    input  wire logic i_clk_sys,
    input  wire logic i_resetn,
    input  wire logic i_fault_n,
    input  wire logic i_reset_req,
    output logic      o_device_reset_n
);
    int   since_fall;
    int   held;
    logic fault_prev;

    // reset pulse on request, released only after the hold time
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            since_fall <= HOLD_CYC;
            held <= 0;
            fault_prev <= 1'h1;
            o_device_reset_n <= 1'h1;
        end else begin
            fault_prev <= i_fault_n;
            if (fault_prev && !i_fault_n) begin
                since_fall <= 0;
            end else if (since_fall < HOLD_CYC) begin
                since_fall <= since_fall + 1;
            end
            if (i_reset_req) begin
                o_device_reset_n <= 1'h0;
                held <= 0;
            end else if (!o_device_reset_n) begin
                held <= held + 1;
                if (held >= 4 && since_fall >= HOLD_CYC) begin
                    o_device_reset_n <= 1'h1;
                end
            end
        end
    end
endmodule

// File: verif/amp_output_protection_ctrl_tb.sv
// testbench of the output protection controller
// assumes the controller model and a 50 MHz clock
`timescale 1ns/100ps
module amp_output_protection_ctrl_tb;
    logic        clk = 1'h0;
    logic        rstn = 1'h0;
    logic [3:0]  set = 4'h0;
    logic [3:0]  oc = 4'h0;
    logic [3:0]  fc = 4'h0;
    logic        frm = 1'h0;
    logic        clip = 1'h0;
    logic        warm = 1'h0;
    logic        hot = 1'h0;
    logic        sok = 1'h1;
    logic        lup = 1'h0;
    logic        sgnd = 1'h1;
    logic        ssup = 1'h0;
    logic [1:0]  imb = 2'h0;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic        req = 1'h0;
    logic [31:0] prd;
    logic [31:0] rd;
    logic        rdy;
    logic        perr;
    logic        err;
    logic        drst_n;
    logic [3:0]  hiz;
    logic [3:0]  flip;
    logic        inj;
    logic        flt_n;
    logic        wrn_n;
    logic        lim;
    logic [1:0]  thr;
    int          mismatches = 0;
    int          num_checks = 0;

    always #10 clk = ~clk;
    // pwm frame of 16 cycles
    always @(posedge clk) begin
        fc <= fc + 4'h1;
        frm <= ~fc[3];
    end

    amp_output_protection_ctrl #(.OL_MAX(8'h04)) uut (
        .i_clk_sys(clk), .i_resetn(rstn),
        .i_overcurrent_setting_input(set),
        .i_device_reset_n(drst_n), .i_overcurrent(oc),
        .i_pwm_frame(frm), .i_clipping(clip),
        .i_heat_warning(warm), .i_heat_shutdown(hot),
        .i_supplies_ok(sok), .i_logic_supply_up(lup),
        .i_short_to_ground(sgnd), .i_short_to_stage_supply(ssup),
        .i_dc_imbalance(imb), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(perr),
        .o_hiz(hiz), .o_flip(flip), .o_inject(inj),
        .o_fault_n(flt_n), .o_clip_heat_warning_n(wrn_n),
        .o_cycle_limit_mode(lim), .o_oc_threshold(thr)
    );

    sys_ctrl_model #(.HOLD_CYC(100)) ctl (
        .i_clk_sys(clk), .i_resetn(rstn), .i_fault_n(flt_n),
        .i_reset_req(req), .o_device_reset_n(drst_n)
    );

    task close_out;
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task cy(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wait_frame;
        int n;
        n = 0;
        @(posedge clk);
        while (fc !== 4'h0 && n < 40) begin
            n++;
            @(posedge clk);
        end
        if (n == 40) begin
            ck("frame timeout", 1'h0, 1'h1);
            close_out();
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (rdy !== 1'h1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) begin
            ck("ready timeout", 1'h0, 1'h1);
            close_out();
        end
        rd = prd;
        err = perr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask

    task wait_run;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[15:12] !== 4'h8 && n < 1000) begin
            cy(20);
            apb(1'h0, 12'h004, 32'h0);
            n++;
        end
        if (n == 1000) begin
            ck("run timeout", 1'h0, 1'h1);
            close_out();
        end
    endtask

    task dev_reset;
        int n;
        n = 0;
        req <= 1'h1;
        cy(8);
        ck("fault_n in reset", 1'h1, flt_n);
        req <= 1'h0;
        while (drst_n !== 1'h1 && n < 500) begin
            n++;
            @(posedge clk);
        end
        if (n == 500) begin
            ck("reset timeout", 1'h0, 1'h1);
            close_out();
        end
        cy(6);
    endtask

    task s_startup;
        apb(1'h0, 12'h000, 32'h0);
        ck("cfg", 32'h0, rd);
        apb(1'h0, 12'h008, 32'h0);
        ck("count", 32'h0, rd);
        apb(1'h0, 12'h00C, 32'h0);
        ck("unmapped err", 1'h1, err);
        ck("unmapped data", 32'h0, rd);
        apb(1'h0, 12'h004, 32'h0);
        ck("wait supply", 4'h1, rd[15:12]);
        lup <= 1'h1;
        cy(3000);
        apb(1'h0, 12'h004, 32'h0);
        ck("gnd step", 4'h2, rd[15:12]);
        ck("hiz gnd short", 4'hF, hiz);
        req <= 1'h1;
        cy(10);
        ck("fault in check", 1'h0, flt_n);
        req <= 1'h0;
        sgnd <= 1'h0;
        ssup <= 1'h1;
        cy(2500);
        apb(1'h0, 12'h004, 32'h0);
        ck("sup step", 4'h4, rd[15:12]);
        ck("hiz sup short", 4'hF, hiz);
        ssup <= 1'h0;
        wait_run();
        cy(6);
        ck("fault released", 1'h1, flt_n);
        ck("hiz released", 4'h0, hiz);
    endtask

    task s_settings;
        for (int s = 0; s < 16; s++) begin
            set <= s[3:0];
            cy(6);
            ck("mode", s < 4 || s > 7, lim);
            ck("thr", s > 7 ? 3 : s % 4, thr);
        end
        set <= 4'h0;
        cy(6);
    endtask

    task s_flip_count;
        wait_frame();
        cy(2);
        oc <= 4'h1;
        cy(2);
        oc <= 4'h0;
        cy(3);
        ck("flip set", 1'h1, flip[0]);
        wait_frame();
        cy(6);
        ck("flip cleared", 1'h0, flip[0]);
        apb(1'h0, 12'h008, 32'h0);
        ck("count up", 8'h01, rd[7:0]);
        wait_frame();
        cy(6);
        apb(1'h0, 12'h008, 32'h0);
        ck("count down", 8'h00, rd[7:0]);
    endtask

    task s_limit;
        int ni;
        ni = 0;
        oc <= 4'h4;
        repeat (112) begin
            @(posedge clk);
            if (inj === 1'h1) ni++;
        end
        oc <= 4'h0;
        cy(6);
        ck("inject", 1'h1, ni > 0);
        ck("ch1 shut", 2'h3, hiz[3:2]);
        ck("ch0 on", 2'h0, hiz[1:0]);
        ck("fault", 1'h0, flt_n);
        dev_reset();
        ck("hiz after reset", 4'h0, hiz);
        apb(1'h0, 12'h004, 32'h0);
        ck("no recheck", 4'h8, rd[15:12]);
    endtask

    task s_latched;
        set <= 4'h4;
        cy(6);
        oc <= 4'h1;
        @(posedge clk);
        oc <= 4'h0;
        cy(6);
        ck("latched shut", 2'h3, hiz[1:0]);
        ck("latched fault", 1'h0, flt_n);
        cy(20);
        apb(1'h0, 12'h008, 32'h0);
        ck("no count", 32'h0, rd);
        dev_reset();
        ck("latched clear", 4'h0, hiz);
        set <= 4'h0;
        cy(6);
    endtask

    task s_heat;
        int nw;
        nw = 0;
        clip <= 1'h1;
        repeat (80) begin
            @(posedge clk);
            if (wrn_n === 1'h0) nw++;
        end
        clip <= 1'h0;
        cy(6);
        ck("clip warn", 1'h1, nw > 0);
        ck("clip cleared", 1'h1, wrn_n);
        warm <= 1'h1;
        cy(6);
        ck("warn", 1'h0, wrn_n);
        ck("warn no fault", 1'h1, flt_n);
        warm <= 1'h0;
        hot <= 1'h1;
        cy(6);
        hot <= 1'h0;
        cy(6);
        ck("heat hiz", 4'hF, hiz);
        ck("heat fault", 1'h0, flt_n);
        dev_reset();
        ck("heat clear", 4'h0, hiz);
        ck("heat fault clr", 1'h1, flt_n);
    endtask

    task s_supply_dc;
        sok <= 1'h0;
        cy(6);
        ck("low hiz", 4'hF, hiz);
        ck("low fault", 1'h0, flt_n);
        sok <= 1'h1;
        cy(6);
        ck("recover hiz", 4'h0, hiz);
        ck("recover fault", 1'h1, flt_n);
        imb <= 2'h2;
        cy(112);
        ck("dc shut", 2'h3, hiz[3:2]);
        imb <= 2'h0;
        dev_reset();
        apb(1'h1, 12'h000, 32'h1);
        imb <= 2'h1;
        cy(112);
        ck("dc parallel", 4'h0, hiz);
        imb <= 2'h0;
        apb(1'h1, 12'h000, 32'h2);
        imb <= 2'h1;
        lup <= 1'h0;
        cy(6);
        lup <= 1'h1;
        cy(8);
        apb(1'h0, 12'h004, 32'h0);
        ck("single skip", 4'h8, rd[15:12]);
        cy(112);
        ck("dc single", 4'h0, hiz);
        imb <= 2'h0;
        apb(1'h1, 12'h000, 32'h0);
    endtask

    initial begin
        cy(16);
        rstn <= 1'h1;
        cy(2);
        s_startup();
        s_settings();
        s_flip_count();
        s_limit();
        s_latched();
        s_heat();
        s_supply_dc();
        close_out();
    end
endmodule
